// ==== inc/eesc_pkg.sv ====
package eesc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RELOAD = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    // control field positions
    localparam int CTRL_ARM = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_ENC = 4;
    localparam int CTRL_PHASE = 6;
    localparam int CTRL_SAMP_POL = 8;
    localparam int CTRL_START_POL = 9;
    localparam int CTRL_STOP_POL = 10;
    localparam int CTRL_SRC_POL = 11;
    localparam int CTRL_RELOAD_EN = 12;
    // status field positions
    localparam int ST_OVERRUN = 0;
    localparam int ST_LOST = 1;
    localparam int ST_DONE = 2;
    localparam int ST_ARMED = 3;
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] RELOAD_RESET = 32'h0000_0000;
    // synchronised pin indices
    localparam int NUM_PINS = 7;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_Z = 2;
    localparam int PIN_GATE = 3;
    localparam int PIN_AUX = 4;
    localparam int PIN_SRC = 5;
    localparam int PIN_SAMP = 6;
    // reload latency bound: one period of the fastest timebase
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int RELOAD_DELAY_NS = 25;
    localparam int RELOAD_DELAY_CYCLES = RELOAD_DELAY_NS / CLOCK_PERIOD_NS;

    typedef enum logic [2:0] {
        MODE_POS, MODE_POS_BUF, MODE_SEP_SINGLE, MODE_SEP_IMPL, MODE_SEP_SAMP
    } eesc_mode_type;

    typedef enum logic [1:0] {
        SINGLE_EDGE_DECODING, DOUBLE_EDGE_DECODING, QUAD_EDGE_DECODING, TWO_PULSE
    } eesc_enc_type;

    typedef enum logic [1:0] {
        SEP_WAIT_START, SEP_COUNTING, SEP_WAIT_RESTART, SEP_DONE
    } eesc_sep_type;
endpackage

// ==== core/eesc_sync.sv ====
`timescale 1ns/100ps
module eesc_sync (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [eesc_pkg::NUM_PINS-1:0] din,
    output logic [eesc_pkg::NUM_PINS-1:0] level,
    output logic [eesc_pkg::NUM_PINS-1:0] rise,
    output logic [eesc_pkg::NUM_PINS-1:0] fall
);
    logic [eesc_pkg::NUM_PINS-1:0] stage1_r;
    logic [eesc_pkg::NUM_PINS-1:0] stage2_r;
    logic [eesc_pkg::NUM_PINS-1:0] prev_r;

    // edges are taken between stage two and a third copy, never from stage one
    for (genvar i = 0; i < eesc_pkg::NUM_PINS; i++)
    begin : g_pin
        always_ff @(posedge clock or negedge resetn)
        begin
            if (!resetn)
            begin
                stage1_r[i] <= 1'b0;
                stage2_r[i] <= 1'b0;
                prev_r[i] <= 1'b0;
            end
            else
            begin
                stage1_r[i] <= din[i];
                stage2_r[i] <= stage1_r[i];
                prev_r[i] <= stage2_r[i];
            end
        end
        assign level[i] = stage2_r[i];
        assign rise[i] = stage2_r[i] & ~prev_r[i];
        assign fall[i] = ~stage2_r[i] & prev_r[i];
    end
endmodule

// ==== core/eesc_quad.sv ====
`timescale 1ns/100ps
module eesc_quad (
    input wire logic aLvl,
    input wire logic bLvl,
    input wire logic aRise,
    input wire logic aFall,
    input wire logic bRise,
    input wire logic bFall,
    input wire eesc_pkg::eesc_enc_type enc,
    output logic up,
    output logic dn
);
    logic x1Up;
    logic x1Dn;
    logic x2Up;
    logic x2Dn;
    logic x4Up;
    logic x4Dn;

    // a leading b: a rises with b low; b leading: a falls with b low
    assign x1Up = aRise & ~bLvl;
    assign x1Dn = aFall & ~bLvl;
    assign x2Up = x1Up | (aFall & bLvl);
    assign x2Dn = x1Dn | (aRise & bLvl);
    assign x4Up = x2Up | (bRise & aLvl) | (bFall & ~aLvl);
    assign x4Dn = x2Dn | (bRise & ~aLvl) | (bFall & aLvl);

    always_comb
    begin
        up = 1'b0;
        dn = 1'b0;
        case (enc)
            eesc_pkg::SINGLE_EDGE_DECODING:
            begin
                up = x1Up;
                dn = x1Dn;
            end
            eesc_pkg::DOUBLE_EDGE_DECODING:
            begin
                up = x2Up;
                dn = x2Dn;
            end
            eesc_pkg::QUAD_EDGE_DECODING:
            begin
                up = x4Up;
                dn = x4Dn;
            end
            eesc_pkg::TWO_PULSE:
            begin
                // coincident edges on both tracks cancel
                up = aRise & ~bRise;
                dn = bRise & ~aRise;
            end
            default:
            begin
                up = 1'b0;
                dn = 1'b0;
            end
        endcase
    end
endmodule

// ==== core/eesc_core.sv ====
// How it works
// - index high during chosen phase loads the reload value into the counter.
// - reload phase is selectable as any one of four a/b states.
// - a count step wins over reload; reload follows on the next cycle.
// - reload completes within one timebase period of the condition.
// - after reload, counting carries on in the same mode.
// - two-pulse mode adds one on each track a rising edge.
// - two-pulse mode subtracts one on each track b rising edge.
// - buffered position counts from arm and captures on sample edges.
// - captures are cumulative; sampling never clears the counter.
// - sample clock polarity is selectable.
// - captured values leave through the stream port.
// - separation count starts on aux edge, stops on gate edge.
// - while counting, timebase edges count and further aux edges are ignored.
// - stop edge halts counting and pushes the count; sample-clocked mode holds it instead.
// - aux and gate polarities are chosen independently.
// - single mode ignores everything after one stored count.
// - implicit mode restarts on the next gate edge after each store.
// - sample-clocked mode pushes the held count on a sample edge.
// - sample period without both start and stop flags overrun.
// - quadrature decoding gives one, two or four steps per cycle.
// - single-edge decoding steps on track a edges only.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module eesc_core (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trackA,
    input wire logic trackB,
    input wire logic indexZ,
    input wire logic gateIn,
    input wire logic auxIn,
    input wire logic sourceIn,
    input wire logic sampleClk,
    output logic [31:0] streamData,
    output logic streamValid,
    input wire logic streamReady
);
    logic [31:0] ctrl_r;
    logic [31:0] reload_r;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic [31:0] held_r;
    logic heldValid_r;
    logic sawStart_r;
    logic sawStop_r;
    logic overrun_r;
    logic lost_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] streamData_r;
    logic streamValid_r;
    eesc_pkg::eesc_sep_type sep_r;
    eesc_pkg::eesc_sep_type sep_nxt;

    // pins
    logic [eesc_pkg::NUM_PINS-1:0] pinRaw;
    logic [eesc_pkg::NUM_PINS-1:0] pinLvl;
    logic [eesc_pkg::NUM_PINS-1:0] pinRise;
    logic [eesc_pkg::NUM_PINS-1:0] pinFall;
    assign pinRaw = {sampleClk, sourceIn, auxIn, gateIn, indexZ, trackB, trackA};

    eesc_sync u_sync (
        .clock(clock),
        .resetn(resetn),
        .din(pinRaw),
        .level(pinLvl),
        .rise(pinRise),
        .fall(pinFall)
    );

    // configuration decode
    wire eesc_pkg::eesc_mode_type modeSel =
        eesc_pkg::eesc_mode_type'(ctrl_r[eesc_pkg::CTRL_MODE +: 3]);
    wire eesc_pkg::eesc_enc_type encSel =
        eesc_pkg::eesc_enc_type'(ctrl_r[eesc_pkg::CTRL_ENC +: 2]);
    wire [1:0] phaseSel = ctrl_r[eesc_pkg::CTRL_PHASE +: 2];
    wire armed = ctrl_r[eesc_pkg::CTRL_ARM];
    wire posMode = (modeSel == eesc_pkg::MODE_POS) | (modeSel == eesc_pkg::MODE_POS_BUF);
    wire sepSingle = modeSel == eesc_pkg::MODE_SEP_SINGLE;
    wire sepSamp = modeSel == eesc_pkg::MODE_SEP_SAMP;
    wire sepMode = sepSingle | sepSamp | (modeSel == eesc_pkg::MODE_SEP_IMPL);
    wire sepArmed = armed & sepMode;

    // active edges with independent polarity
    wire startEdge = ctrl_r[eesc_pkg::CTRL_START_POL] ? pinFall[eesc_pkg::PIN_AUX]
                                                      : pinRise[eesc_pkg::PIN_AUX];
    wire stopEdge = ctrl_r[eesc_pkg::CTRL_STOP_POL] ? pinFall[eesc_pkg::PIN_GATE]
                                                    : pinRise[eesc_pkg::PIN_GATE];
    wire srcEdge = ctrl_r[eesc_pkg::CTRL_SRC_POL] ? pinFall[eesc_pkg::PIN_SRC]
                                                  : pinRise[eesc_pkg::PIN_SRC];
    wire sampEdge = ctrl_r[eesc_pkg::CTRL_SAMP_POL] ? pinFall[eesc_pkg::PIN_SAMP]
                                                    : pinRise[eesc_pkg::PIN_SAMP];

    // position decoding
    logic qUp;
    logic qDn;
    eesc_quad u_quad (
        .aLvl(pinLvl[eesc_pkg::PIN_A]),
        .bLvl(pinLvl[eesc_pkg::PIN_B]),
        .aRise(pinRise[eesc_pkg::PIN_A]),
        .aFall(pinFall[eesc_pkg::PIN_A]),
        .bRise(pinRise[eesc_pkg::PIN_B]),
        .bFall(pinFall[eesc_pkg::PIN_B]),
        .enc(encSel),
        .up(qUp),
        .dn(qDn)
    );
    wire stepUp = armed & posMode & qUp;
    wire stepDn = armed & posMode & qDn;
    wire phaseMatch = {pinLvl[eesc_pkg::PIN_B], pinLvl[eesc_pkg::PIN_A]} == phaseSel;
    wire phaseHit = armed & posMode & ctrl_r[eesc_pkg::CTRL_RELOAD_EN]
                    & phaseMatch & pinLvl[eesc_pkg::PIN_Z];

    // apb decode: one wait state so read data comes from a flop
    wire apbAccess = psel & penable;
    wire apbDone = apbAccess & pready_r;
    wire hitCtrl = paddr == eesc_pkg::OFF_CTRL;
    wire hitReload = paddr == eesc_pkg::OFF_RELOAD;
    wire hitCount = paddr == eesc_pkg::OFF_COUNT;
    wire hitStatus = paddr == eesc_pkg::OFF_STATUS;
    wire addrHit = hitCtrl | hitReload | hitCount | hitStatus;
    wire wrCtrl = apbDone & pwrite & hitCtrl;
    wire wrReload = apbDone & pwrite & hitReload;
    wire wrStatus = apbDone & pwrite & hitStatus;
    wire armStart = wrCtrl & pwdata[eesc_pkg::CTRL_ARM] & ~armed;

    logic [31:0] statusWord;
    always_comb
    begin
        statusWord = 32'h0000_0000;
        statusWord[eesc_pkg::ST_OVERRUN] = overrun_r;
        statusWord[eesc_pkg::ST_LOST] = lost_r;
        statusWord[eesc_pkg::ST_DONE] = sep_r == eesc_pkg::SEP_DONE;
        statusWord[eesc_pkg::ST_ARMED] = armed;
    end

    wire [31:0] rdMux = hitCtrl ? ctrl_r
                      : hitReload ? reload_r
                      : hitCount ? cnt_r
                      : hitStatus ? statusWord : 32'h0000_0000;

    // separation sequencer
    always_comb
    begin
        sep_nxt = sep_r;
        case (sep_r)
            eesc_pkg::SEP_WAIT_START:
                if (startEdge)
                    sep_nxt = eesc_pkg::SEP_COUNTING;
            eesc_pkg::SEP_COUNTING:
                if (stopEdge)
                    sep_nxt = sepSingle ? eesc_pkg::SEP_DONE
                                        : eesc_pkg::SEP_WAIT_RESTART;
            eesc_pkg::SEP_WAIT_RESTART:
                if (stopEdge)
                    sep_nxt = eesc_pkg::SEP_COUNTING;
            eesc_pkg::SEP_DONE:
                sep_nxt = eesc_pkg::SEP_DONE;
            default:
                sep_nxt = eesc_pkg::SEP_WAIT_START;
        endcase
        if (armStart | ~sepArmed)
            sep_nxt = eesc_pkg::SEP_WAIT_START;
    end

    wire counting = sep_r == eesc_pkg::SEP_COUNTING;
    wire intervalStart = sepArmed & ~counting & (sep_nxt == eesc_pkg::SEP_COUNTING);
    wire intervalStop = sepArmed & counting & stopEdge;

    // arm clears, count steps beat reload, reload last
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (armStart)
            cnt_nxt = 32'h0000_0000;
        else if (intervalStart)
            cnt_nxt = 32'h0000_0000;
        else if (sepArmed & counting & srcEdge)
            cnt_nxt = cnt_r + 32'h0000_0001;
        else if (stepUp)
            cnt_nxt = cnt_r + 32'h0000_0001;
        else if (stepDn)
            cnt_nxt = cnt_r - 32'h0000_0001;
        else if (phaseHit)
            cnt_nxt = reload_r;
    end

    // stream slot
    wire posSample = armed & (modeSel == eesc_pkg::MODE_POS_BUF) & sampEdge;
    wire sampPush = sepArmed & sepSamp & sampEdge & heldValid_r;
    wire pushReq = posSample | (intervalStop & ~sepSamp) | sampPush;
    wire [31:0] pushData = sepSamp ? held_r : cnt_r;
    wire slotFree = ~streamValid_r | streamReady;
    wire ovrSet = sepArmed & sepSamp & sampEdge & ~(sawStart_r & sawStop_r);
    wire lostSet = pushReq & ~slotFree;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= apbAccess & ~pready_r;
            pslverr_r <= apbAccess & ~pready_r & ~addrHit;
            prdata_r <= (apbAccess & ~pready_r & ~pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_r <= eesc_pkg::CTRL_RESET;
            reload_r <= eesc_pkg::RELOAD_RESET;
        end
        else
        begin
            if (wrCtrl)
                ctrl_r <= pwdata;
            if (wrReload)
                reload_r <= pwdata;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_r <= 32'h0000_0000;
            sep_r <= eesc_pkg::SEP_WAIT_START;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            sep_r <= sep_nxt;
        end
    end

    // sample-clocked holding stage; a stop in the sample cycle refills it
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            held_r <= 32'h0000_0000;
            heldValid_r <= 1'b0;
            sawStart_r <= 1'b0;
            sawStop_r <= 1'b0;
        end
        else if (armStart | ~sepArmed)
        begin
            heldValid_r <= 1'b0;
            sawStart_r <= 1'b0;
            sawStop_r <= 1'b0;
        end
        else
        begin
            if (intervalStop & sepSamp)
                held_r <= cnt_r;
            heldValid_r <= (intervalStop & sepSamp) | (heldValid_r & ~sampEdge);
            sawStart_r <= startEdge | (sawStart_r & ~sampEdge);
            sawStop_r <= stopEdge | (sawStop_r & ~sampEdge);
        end
    end

    // sticky flags: write one clears, a set in the same cycle wins
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            overrun_r <= 1'b0;
            lost_r <= 1'b0;
        end
        else
        begin
            overrun_r <= ovrSet | (overrun_r & ~(wrStatus & pwdata[eesc_pkg::ST_OVERRUN]));
            lost_r <= lostSet | (lost_r & ~(wrStatus & pwdata[eesc_pkg::ST_LOST]));
        end
    end

    // a full slot drops the new value rather than stalling the counter
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            streamData_r <= 32'h0000_0000;
            streamValid_r <= 1'b0;
        end
        else if (pushReq & slotFree)
        begin
            streamData_r <= pushData;
            streamValid_r <= 1'b1;
        end
        else if (streamReady)
            streamValid_r <= 1'b0;
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign streamData = streamData_r;
    assign streamValid = streamValid_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence s_reloadCond;
        phaseHit & ~stepUp & ~stepDn & ~armStart;
    endsequence

    sequence s_stepIntoPhase;
        stepUp & phaseHit & ~armStart;
    endsequence

    reload_load_a: assert property (s_reloadCond |=> cnt_r == $past(reload_r))
        else $error("index reload did not load the reload value");
    step_first_a: assert property (s_stepIntoPhase |=> cnt_r == $past(cnt_r) + 32'h1 ##1
        (cnt_r == $past(reload_r, 2) || !$past(phaseHit)))
        else $error("count step did not precede index reload");
    pulse_up_a: assert property (armed & posMode & (encSel == eesc_pkg::TWO_PULSE)
        & pinRise[eesc_pkg::PIN_A] & ~pinRise[eesc_pkg::PIN_B] & ~armStart
        |=> cnt_r == $past(cnt_r) + 32'h1)
        else $error("two-pulse track a edge did not add one");
    pulse_down_a: assert property (armed & posMode & (encSel == eesc_pkg::TWO_PULSE)
        & pinRise[eesc_pkg::PIN_B] & ~pinRise[eesc_pkg::PIN_A] & ~armStart
        |=> cnt_r == $past(cnt_r) - 32'h1)
        else $error("two-pulse track b edge did not subtract one");
    pos_capture_a: assert property (posSample & slotFree
        |=> streamValid && streamData == $past(cnt_r))
        else $error("sample edge did not capture the count");
    stop_push_a: assert property (intervalStop & ~sepSamp & slotFree
        |=> streamValid && streamData == $past(cnt_r) && !counting)
        else $error("stop edge did not store the count");
    single_hold_a: assert property (sep_r == eesc_pkg::SEP_DONE & sepArmed & ~armStart
        |=> sep_r == eesc_pkg::SEP_DONE && $stable(cnt_r))
        else $error("single measurement left its done state");
    overrun_flag_a: assert property (ovrSet |=> overrun_r)
        else $error("missing start or stop did not flag overrun");
    start_clear_a: assert property (intervalStart & ~armStart
        |=> cnt_r == 32'h0 && counting)
        else $error("interval start did not clear the counter");
endmodule

// ==== verification/eesc_src_model.sv ====
`timescale 1ns/100ps
module eesc_src_model #(parameter int GAP = 6) (
    input wire logic clock,
    output logic trackA,
    output logic trackB,
    output logic indexZ,
    output logic gateIn,
    output logic auxIn,
    output logic sourceIn,
    output logic sampleClk
);
    logic [1:0] q;
    initial
    begin
        {trackA, trackB, indexZ, gateIn, auxIn, sourceIn, sampleClk} = '0;
        q = 2'h0;
    end
    // levels stay put long enough to pass the pin synchronisers
    task automatic hold();
        repeat (GAP) @(posedge clock);
    endtask
    // quadrature walk of {b,a}: 00, 01, 11, 10 when going forward
    task automatic step(input logic fwd);
        q = fwd ? q + 2'h1 : q - 2'h1;
        @(posedge clock);
        trackA <= q[0] ^ q[1];
        trackB <= q[1];
        hold();
    endtask
    // pin ids: 0 aux, 1 gate, 2 timebase, 3 sample, 4 a, 5 b, 6 index
    task automatic put(input int p, input logic v);
        @(posedge clock);
        case (p)
            0: auxIn <= v;
            1: gateIn <= v;
            2: sourceIn <= v;
            3: sampleClk <= v;
            4: trackA <= v;
            5: trackB <= v;
            default: indexZ <= v;
        endcase
        hold();
    endtask
    task automatic pulse(input int p, input int n);
        repeat (n)
        begin
            put(p, 1'b1);
            put(p, 1'b0);
        end
    endtask
endmodule

// ==== verification/tb_encoder_edge_sep_counter.sv ====
`timescale 1ns/100ps
module tb_encoder_edge_sep_counter;
    localparam int AUX = 0;
    localparam int GATE = 1;
    localparam int SRC = 2;
    localparam int SMP = 3;
    localparam int PA = 4;
    localparam int PB = 5;
    localparam int PZ = 6;
    logic clock, resetn, psel, penable, pwrite, pready, pslverr, streamValid;
    logic streamReady;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, streamData, rv;
    logic trackA, trackB, indexZ, gateIn, auxIn, sourceIn, sampleClk;
    logic [32:0] apbQ[$];
    logic [32:0] stQ[$];
    int errors = 0;
    int n_compared = 0;
    int n, m, k;

    eesc_core i_dut (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .trackA, .trackB, .indexZ, .gateIn, .auxIn,
        .sourceIn, .sampleClk, .streamData, .streamValid, .streamReady);
    eesc_src_model #(.GAP(6)) i_src (.clock, .trackA, .trackB, .indexZ, .gateIn,
        .auxIn, .sourceIn, .sampleClk);

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
        apbQ.push_back({err, exp});
        xfer(1'b0, a, 32'h0);
    endtask

    // pol bits: sample, aux, gate, timebase, index reload enable
    function automatic logic [31:0] ctl(input int md, input int en, input int ph, input int pol);
        ctl = 32'(md) << eesc_pkg::CTRL_MODE | 32'(en) << eesc_pkg::CTRL_ENC;
        ctl = ctl | 32'(ph) << eesc_pkg::CTRL_PHASE | 32'(pol) << eesc_pkg::CTRL_SAMP_POL;
    endfunction

    // arm only rises after a write with arm low, so the counter is cleared
    task automatic arm(input logic [31:0] c);
        wr(eesc_pkg::OFF_CTRL, c);
        wr(eesc_pkg::OFF_CTRL, c | 32'h1);
    endtask

    always @(posedge clock)
        if (psel && penable && !pwrite && pready === 1'b1)
            check({pslverr, prdata}, apbQ.size() > 0 ? apbQ.pop_front() : 'x);

    // an unexpected push meets an empty queue and fails
    always @(posedge clock)
        if (streamValid === 1'b1 && streamReady === 1'b1)
            check({1'b0, streamData}, stQ.size() > 0 ? stQ.pop_front() : 'x);

    always @(posedge clock)
        streamReady <= ($urandom % 4) != 0;

    initial
    begin
        #500000;
        errors++;
        finish_test();
    end

    initial
    begin
        resetn = 1'b0;
        {psel, penable} = '0;
        void'($urandom(79));
        // idle bus fields carry random values; nothing may be taken while psel is low
        pwrite = 1'($urandom);
        paddr = 8'($urandom);
        pwdata = $urandom;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        rd(eesc_pkg::OFF_CTRL, eesc_pkg::CTRL_RESET);
        rd(eesc_pkg::OFF_RELOAD, eesc_pkg::RELOAD_RESET);
        rd(eesc_pkg::OFF_STATUS, 32'h0);
        rv = $urandom;
        wr(eesc_pkg::OFF_RELOAD, rv);
        rd(eesc_pkg::OFF_RELOAD, rv);
        wr(eesc_pkg::OFF_COUNT, rv);
        rd(eesc_pkg::OFF_COUNT, 32'h0);
        rd(8'h10, 32'h0, 1'b1);
        n = 1 + $urandom % 6;
        m = $urandom % 4;
        arm(ctl(0, 3, 0, 0));
        i_src.pulse(PA, n);
        i_src.pulse(PB, m);
        rd(eesc_pkg::OFF_COUNT, 32'(n - m));
        for (int e = 0; e < 3; e++)
        begin
            k = 1 << e;
            arm(ctl(0, e, 0, 0));
            repeat (4) i_src.step(1'b1);
            rd(eesc_pkg::OFF_COUNT, 32'(k));
            repeat (8) i_src.step(1'b0);
            rd(eesc_pkg::OFF_COUNT, 32'(-k));
        end
        i_src.step(1'b0);
        for (int p = 0; p < 4; p++)
        begin
            rv = $urandom;
            wr(eesc_pkg::OFF_RELOAD, rv);
            arm(ctl(0, 2, (p & 2) | ((p ^ (p >> 1)) & 1), 16));
            i_src.put(PZ, 1'b1);
            i_src.step(1'b1);
            rd(eesc_pkg::OFF_COUNT, rv);
            i_src.put(PZ, 1'b0);
            i_src.step(1'b1);
            rd(eesc_pkg::OFF_COUNT, rv + 32'h1);
            i_src.step(1'b0);
        end
        i_src.step(1'b1);
        for (int s = 0; s < 2; s++)
        begin
            arm(ctl(1, 3, 0, s));
            stQ.push_back(33'(3 + s));
            stQ.push_back(33'h6);
            i_src.pulse(PA, 3);
            i_src.put(SMP, 1'b1);
            i_src.pulse(PA, 1);
            i_src.put(SMP, 1'b0);
            i_src.pulse(PA, 2);
            i_src.pulse(SMP, 1);
        end
        wr(eesc_pkg::OFF_CTRL, ctl(2, 0, 0, 2));
        i_src.pulse(AUX, 1);
        i_src.pulse(SRC, 2);
        wr(eesc_pkg::OFF_CTRL, ctl(2, 0, 0, 2) | 32'h1);
        i_src.pulse(GATE, 1);
        stQ.push_back(33'(n));
        i_src.put(AUX, 1'b1);
        i_src.pulse(SRC, 1);
        i_src.put(AUX, 1'b0);
        i_src.pulse(SRC, 1);
        i_src.pulse(AUX, 1);
        i_src.pulse(SRC, n - 1);
        i_src.put(GATE, 1'b1);
        i_src.pulse(SRC, 1);
        i_src.put(GATE, 1'b0);
        i_src.pulse(AUX, 1);
        i_src.pulse(SRC, 2);
        i_src.pulse(GATE, 1);
        rd(eesc_pkg::OFF_STATUS, 32'hC);
        m = 1 + $urandom % 4;
        arm(ctl(3, 0, 0, 12));
        stQ.push_back(33'(n + 1));
        stQ.push_back(33'(m));
        i_src.pulse(AUX, 1);
        i_src.pulse(SRC, n);
        i_src.put(GATE, 1'b1);
        i_src.pulse(SRC, 1);
        i_src.put(GATE, 1'b0);
        i_src.pulse(SRC, 1);
        i_src.pulse(GATE, 1);
        i_src.pulse(SRC, m);
        i_src.pulse(GATE, 1);
        arm(ctl(4, 0, 0, 0));
        i_src.pulse(SMP, 1);
        rd(eesc_pkg::OFF_STATUS, 32'h9);
        wr(eesc_pkg::OFF_STATUS, 32'h1);
        rd(eesc_pkg::OFF_STATUS, 32'h8);
        i_src.pulse(AUX, 1);
        i_src.pulse(SRC, n);
        i_src.pulse(GATE, 1);
        stQ.push_back(33'(n));
        i_src.pulse(SMP, 1);
        rd(eesc_pkg::OFF_STATUS, 32'h8);
        repeat (10) @(posedge clock);
        check(33'(stQ.size() + apbQ.size()), 33'h0);
        finish_test();
    end
endmodule
